// ==== pkg/mhrp_pkg.sv ====
// constants and types for the motion host register port
package mhrp_pkg;
    localparam int MHRP_CLK_MHZ = 100;
    localparam int MHRP_BUSY_NS = 250;
    localparam int MHRP_BUSY_CYC = (MHRP_BUSY_NS * MHRP_CLK_MHZ) / 1000;
    localparam int MHRP_RESET_BUSY_NS = 875;
    localparam int MHRP_RESET_BUSY_CYC = (MHRP_RESET_BUSY_NS * MHRP_CLK_MHZ) / 1000;
    localparam logic [2:0] MHRP_SLOT_CMD = 3'h0;
    localparam logic [2:0] MHRP_SLOT_MAIN_STATUS = 3'h0;
    localparam logic [2:0] MHRP_SLOT_AXIS_STATUS_FIRST = 3'h1;
    localparam logic [2:0] MHRP_SLOT_AXIS_ERROR_HOME = 3'h2;
    localparam logic [2:0] MHRP_SLOT_AXIS_INT_CAUSE = 3'h3;
    localparam logic [2:0] MHRP_SLOT_INPUT_FIRST = 3'h4;
    localparam logic [2:0] MHRP_SLOT_INPUT_SECOND = 3'h5;
    localparam logic [2:0] MHRP_SLOT_DATA_LOW = 3'h6;
    localparam logic [2:0] MHRP_SLOT_DATA_HIGH = 3'h7;
    localparam int MHRP_CODE_LSB = 0;
    localparam int MHRP_CODE_MSB = 6;
    localparam int MHRP_AXIS_LSB = 8;
    localparam int MHRP_AXIS_MSB = 11;
    localparam int MHRP_RESET_BIT = 15;
    localparam logic [15:0] MHRP_RESET_WORD = 16'h8000;
    localparam logic [6:0] MHRP_CMD_AXIS_SELECT = 7'h1f;
    localparam logic [3:0] MHRP_AXIS_RESET = 4'h1;
    localparam logic [15:0] MHRP_MODE_RESET = 16'h0000;
    localparam logic [15:0] MHRP_WORD_RESET = 16'h0000;
    typedef enum logic [1:0] {MHRP_IDLE, MHRP_BUSY} mhrp_state_t;
endpackage

// ==== logic/mhrp_busy_timer.sv ====
// busy timer holding the busy level for a loaded count of cycles
`timescale 1ns/100ps
module mhrp_busy_timer
    import mhrp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [7:0] i_count,
    output logic o_busy
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (i_start) begin
            cnt_d = i_count;
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    assign o_busy = (cnt_q != 8'h00);
endmodule

// ==== logic/mhrp_port.sv ====
// parallel host register port of a four-axis motion controller
//
// Overview of operation
// - all readable registers are 16 bits; A2..A0 pick one of eight slots
// - slot 0 read returns the main status word
// - slot 1 read returns first status word of selected axis
// - slot 2 gives selected axis errors/home state; slot 3 its interrupt causes
// - slots 4 and 5 return input pin levels of axis pairs
// - slots 6 and 7 return low and high halves of data-read value
// - per-axis registers share an address; axis-select command routes them
// - 8-bit bus: low byte at even address, high byte at odd
// - byte addresses 0..15 map onto low/high bytes of slots 0..7
// - a completed command write while not busy starts execution immediately
// - data-reading command places 32-bit value into data-read registers
// - busy held low after command write for 26 clocks (260 ns), 88 clocks (880 ns) after the reset word
// - command bits 6..0 carry the command code
// - command bits 11..8 are axis mask; reads use one assigned axis
// - command word with only bit 15 set resets the whole device
// - reset clears axis mode, output and interpolation mode registers
// - output and interpolation mode slots 4 and 5 share storage with second-axis pattern regs
`timescale 1ns/100ps
module mhrp_port
    import mhrp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_bus8,
    input wire logic [3:0] i_addr,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [15:0] i_data,
    output logic [15:0] o_data,
    output logic o_data_oe,
    output logic o_busy_active_low,
    output logic o_cmd_valid,
    output logic [6:0] o_cmd_code,
    output logic [3:0] o_cmd_axes,
    output logic o_device_reset,
    output logic [15:0] o_main_status_unused,
    input wire logic [15:0] i_main_status,
    input wire logic [63:0] i_axis_status_first,
    input wire logic [63:0] i_axis_error_home_status,
    input wire logic [63:0] i_axis_interrupt_cause,
    input wire logic [15:0] i_input_pins_first_pair,
    input wire logic [15:0] i_input_pins_second_pair,
    input wire logic i_read_load,
    input wire logic [31:0] i_read_value,
    output logic [63:0] o_axis_mode_first,
    output logic [63:0] o_axis_mode_second,
    output logic [63:0] o_axis_mode_third,
    output logic [15:0] o_output_mode,
    output logic [15:0] o_interp_mode,
    output logic [15:0] o_pattern_second_plus,
    output logic [15:0] o_pattern_second_minus,
    output logic [31:0] o_data_write
);
    logic [3:0] axis_sel_q, axis_sel_d;
    logic [63:0] mode1_q, mode1_d, mode2_q, mode2_d, mode3_q, mode3_d;
    logic [15:0] out_mode_q, out_mode_d, interp_q, interp_d;
    logic [15:0] dwl_q, dwl_d, dwh_q, dwh_d;
    logic [31:0] rdval_q, rdval_d;
    logic [7:0] cmd_hi_q, cmd_hi_d;
    logic [15:0] dout_q, dout_d;
    logic oe_q, oe_d;
    logic wr_prev_q, rd_prev_q;
    logic cmd_q, cmd_d;
    logic [15:0] cmd_word_q, cmd_word_d;
    mhrp_state_t st_q, st_d;
    logic wr_edge, rd_edge, busy, start;
    logic [2:0] slot;
    logic hi_byte;
    logic [15:0] wdata, rword;
    logic [1:0] ax_idx;
    logic [7:0] busy_count;

    assign wr_edge = !i_cs_n && !i_wr_n && wr_prev_q;
    assign rd_edge = !i_cs_n && !i_rd_n && rd_prev_q;
    assign slot = i_bus8 ? i_addr[3:1] : i_addr[2:0];
    assign hi_byte = i_bus8 & i_addr[0];

    // lowest set axis bit selects the read axis
    always_comb begin
        ax_idx = 2'd0;
        for (int k = 3; k >= 0; k--) begin
            if (axis_sel_q[k]) begin
                ax_idx = 2'(k);
            end
        end
    end

    always_comb begin
        rword = 16'h0000;
        case (slot)
            MHRP_SLOT_MAIN_STATUS: rword = i_main_status;
            MHRP_SLOT_AXIS_STATUS_FIRST: rword = i_axis_status_first[ax_idx*16 +: 16];
            MHRP_SLOT_AXIS_ERROR_HOME: rword = i_axis_error_home_status[ax_idx*16 +: 16];
            MHRP_SLOT_AXIS_INT_CAUSE: rword = i_axis_interrupt_cause[ax_idx*16 +: 16];
            MHRP_SLOT_INPUT_FIRST: rword = i_input_pins_first_pair;
            MHRP_SLOT_INPUT_SECOND: rword = i_input_pins_second_pair;
            MHRP_SLOT_DATA_LOW: rword = rdval_q[15:0];
            MHRP_SLOT_DATA_HIGH: rword = rdval_q[31:16];
            default: rword = 16'h0000;
        endcase
    end

    // merge a byte write into the addressed half of a word
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                          input logic b8, input logic hi);
        logic [15:0] r;
        r = d;
        if (b8) begin
            r = hi ? {d[7:0], old[7:0]} : {old[15:8], d[7:0]};
        end
        return r;
    endfunction

    always_comb begin
        wdata = i_data;
        axis_sel_d = axis_sel_q;
        mode1_d = mode1_q;
        mode2_d = mode2_q;
        mode3_d = mode3_q;
        out_mode_d = out_mode_q;
        interp_d = interp_q;
        dwl_d = dwl_q;
        dwh_d = dwh_q;
        cmd_hi_d = cmd_hi_q;
        cmd_d = 1'b0;
        cmd_word_d = cmd_word_q;
        rdval_d = rdval_q;
        dout_d = dout_q;
        oe_d = !i_cs_n && !i_rd_n;
        if (i_read_load) begin
            rdval_d = i_read_value;
        end
        if (rd_edge) begin
            dout_d = hi_byte ? {8'h00, rword[15:8]} : rword;
            if (i_bus8 && !hi_byte) begin
                dout_d = {8'h00, rword[7:0]};
            end
        end
        if (wr_edge) begin
            case (slot)
                MHRP_SLOT_CMD: begin
                    if (i_bus8 && hi_byte) begin
                        cmd_hi_d = i_data[7:0];
                        if (i_data[7:0] == MHRP_RESET_WORD[15:8]) begin
                            cmd_d = 1'b1;
                            cmd_word_d = MHRP_RESET_WORD;
                        end
                    end else if (o_busy_active_low) begin
                        cmd_d = 1'b1;
                        cmd_word_d = i_bus8 ? {cmd_hi_q, i_data[7:0]} : i_data;
                    end
                end
                3'h1: begin
                    for (int k = 0; k < 4; k++) begin
                        if (axis_sel_q[k]) begin
                            mode1_d[k*16 +: 16] = merge(mode1_q[k*16 +: 16], wdata,
                                                        i_bus8, hi_byte);
                        end
                    end
                end
                3'h2: begin
                    for (int k = 0; k < 4; k++) begin
                        if (axis_sel_q[k]) begin
                            mode2_d[k*16 +: 16] = merge(mode2_q[k*16 +: 16], wdata,
                                                        i_bus8, hi_byte);
                        end
                    end
                end
                3'h3: begin
                    for (int k = 0; k < 4; k++) begin
                        if (axis_sel_q[k]) begin
                            mode3_d[k*16 +: 16] = merge(mode3_q[k*16 +: 16], wdata,
                                                        i_bus8, hi_byte);
                        end
                    end
                end
                3'h4: out_mode_d = merge(out_mode_q, wdata, i_bus8, hi_byte);
                3'h5: interp_d = merge(interp_q, wdata, i_bus8, hi_byte);
                3'h6: dwl_d = merge(dwl_q, wdata, i_bus8, hi_byte);
                3'h7: dwh_d = merge(dwh_q, wdata, i_bus8, hi_byte);
                default: ;
            endcase
        end
        if (cmd_d && cmd_word_d != MHRP_RESET_WORD &&
            cmd_word_d[MHRP_CODE_MSB:MHRP_CODE_LSB] == MHRP_CMD_AXIS_SELECT) begin
            axis_sel_d = cmd_word_d[MHRP_AXIS_MSB:MHRP_AXIS_LSB];
        end
    end

    always_comb begin
        st_d = st_q;
        start = 1'b0;
        busy_count = 8'(MHRP_BUSY_CYC);
        if (cmd_q && cmd_word_q == MHRP_RESET_WORD) begin
            busy_count = 8'(MHRP_RESET_BUSY_CYC);
        end
        case (st_q)
            MHRP_IDLE: begin
                if (cmd_q) begin
                    start = 1'b1;
                    st_d = MHRP_BUSY;
                end
            end
            MHRP_BUSY: begin
                if (!busy && !cmd_q) begin
                    st_d = MHRP_IDLE;
                end
            end
            default: st_d = MHRP_IDLE;
        endcase
    end

    mhrp_busy_timer u_busy (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(start),
        .i_count(busy_count),
        .o_busy(busy)
    );

    always_ff @(posedge i_clk) begin
        if (i_rst || o_device_reset) begin
            axis_sel_q <= MHRP_AXIS_RESET;
            mode1_q <= {4{MHRP_MODE_RESET}};
            mode2_q <= {4{MHRP_MODE_RESET}};
            mode3_q <= {4{MHRP_MODE_RESET}};
            out_mode_q <= MHRP_MODE_RESET;
            interp_q <= MHRP_MODE_RESET;
            dwl_q <= MHRP_WORD_RESET;
            dwh_q <= MHRP_WORD_RESET;
            rdval_q <= {2{MHRP_WORD_RESET}};
            cmd_hi_q <= 8'h00;
            cmd_q <= 1'b0;
            cmd_word_q <= MHRP_WORD_RESET;
            st_q <= MHRP_IDLE;
        end else begin
            axis_sel_q <= axis_sel_d;
            mode1_q <= mode1_d;
            mode2_q <= mode2_d;
            mode3_q <= mode3_d;
            out_mode_q <= out_mode_d;
            interp_q <= interp_d;
            dwl_q <= dwl_d;
            dwh_q <= dwh_d;
            rdval_q <= rdval_d;
            cmd_hi_q <= cmd_hi_d;
            cmd_q <= cmd_d;
            cmd_word_q <= cmd_word_d;
            st_q <= st_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dout_q <= MHRP_WORD_RESET;
            oe_q <= 1'b0;
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
        end else begin
            dout_q <= dout_d;
            oe_q <= oe_d;
            wr_prev_q <= i_cs_n | i_wr_n;
            rd_prev_q <= i_cs_n | i_rd_n;
        end
    end

    assign o_device_reset = cmd_q && (cmd_word_q == MHRP_RESET_WORD);
    assign o_cmd_valid = cmd_q && (cmd_word_q != MHRP_RESET_WORD);
    assign o_cmd_code = cmd_word_q[MHRP_CODE_MSB:MHRP_CODE_LSB];
    assign o_cmd_axes = cmd_word_q[MHRP_AXIS_MSB:MHRP_AXIS_LSB];
    assign o_busy_active_low = !(busy || cmd_q);
    assign o_data = dout_q;
    assign o_data_oe = oe_q;
    assign o_main_status_unused = MHRP_WORD_RESET;
    assign o_axis_mode_first = mode1_q;
    assign o_axis_mode_second = mode2_q;
    assign o_axis_mode_third = mode3_q;
    assign o_output_mode = out_mode_q;
    assign o_interp_mode = interp_q;
    assign o_pattern_second_plus = out_mode_q;
    assign o_pattern_second_minus = interp_q;
    assign o_data_write = {dwh_q, dwl_q};
endmodule

// ==== tb/mhrp_port_checker.sv ====
// assertions on the host register port
`timescale 1ns/100ps
module mhrp_port_checker
    import mhrp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_bus8,
    input wire logic [3:0] i_addr,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [15:0] i_data,
    input wire logic [15:0] o_data,
    input wire logic o_data_oe,
    input wire logic o_busy_active_low,
    input wire logic o_cmd_valid,
    input wire logic [6:0] o_cmd_code,
    input wire logic o_device_reset,
    input wire logic [15:0] i_main_status,
    input wire logic [15:0] i_input_pins_first_pair,
    input wire logic [15:0] i_input_pins_second_pair,
    input wire logic [63:0] o_axis_mode_first,
    input wire logic [15:0] o_output_mode
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_rd;
        !i_cs_n && !i_rd_n && $past(i_cs_n || i_rd_n);
    endsequence
    sequence s_wr;
        !i_cs_n && !i_wr_n && $past(i_cs_n || i_wr_n);
    endsequence
    property p_rd_main;
        s_rd ##0 (!i_bus8 && i_addr[2:0] == MHRP_SLOT_MAIN_STATUS) |-> ##2 o_data == i_main_status;
    endproperty
    a_rd_main: assert property (p_rd_main) else $error("main status read wrong");
    property p_rd_in;
        s_rd ##0 (!i_bus8 && i_addr[2:0] == MHRP_SLOT_INPUT_SECOND)
            |-> ##2 o_data == i_input_pins_second_pair;
    endproperty
    a_rd_in: assert property (p_rd_in) else $error("input pin read wrong");
    property p_rd_byte;
        s_rd ##0 (i_bus8 && i_addr == 4'h9) |-> ##2 o_data == {8'h00, i_input_pins_first_pair[15:8]};
    endproperty
    a_rd_byte: assert property (p_rd_byte) else $error("odd byte read wrong");
    property p_cmd;
        s_wr ##0 (!i_bus8 && i_addr[2:0] == MHRP_SLOT_CMD && o_busy_active_low && !i_data[15])
            |-> ##[1:2] o_cmd_valid;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command not started");
    property p_busy_hold;
        o_cmd_valid && o_cmd_code == MHRP_CMD_AXIS_SELECT
            |-> !o_busy_active_low [*8] ##[1:19] o_busy_active_low;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy length wrong");
    property p_no_cmd_busy;
        o_cmd_valid && !o_device_reset |-> $past(o_busy_active_low);
    endproperty
    a_no_cmd_busy: assert property (p_no_cmd_busy) else $error("command taken while busy");
    property p_reset_clear;
        o_device_reset |-> ##[1:2] (o_axis_mode_first == 64'h0 && o_output_mode == MHRP_MODE_RESET);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("modes not cleared");
    property p_oe;
        !i_cs_n && !i_rd_n && $past(!i_cs_n && !i_rd_n) |-> o_data_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("read drive missing");
endmodule
bind mhrp_port mhrp_port_checker mhrp_port_checker_i (.i_clk, .i_rst, .i_bus8, .i_addr, .i_cs_n,
    .i_rd_n, .i_wr_n, .i_data, .o_data, .o_data_oe, .o_busy_active_low, .o_cmd_valid, .o_cmd_code,
    .o_device_reset, .i_main_status, .i_input_pins_first_pair, .i_input_pins_second_pair,
    .o_axis_mode_first, .o_output_mode);

// ==== tb/mhrp_host.sv ====
// host cpu bus model for the register port
`timescale 1ns/100ps
module mhrp_host (
    input wire logic i_clk,
    input wire logic i_busy_active_low,
    input wire logic [15:0] i_rdata,
    output logic [3:0] o_addr,
    output logic o_cs_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic [15:0] o_data
);
    initial begin
        o_addr = 4'h0;
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_data = 16'h0000;
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk) #1;
        o_addr = a;
        o_data = d;
        o_cs_n = 1'b0;
        o_wr_n = 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        o_data = ~d; // released bus shows no stale value
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clk) #1;
        o_addr = a;
        o_cs_n = 1'b0;
        o_rd_n = 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        d = i_rdata;
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
    endtask
    task automatic cmd(input logic b8, input logic [15:0] w, output bit ok);
        ok = 0;
        for (int i = 0; i < 200 && !ok; i++) begin
            @(posedge i_clk) #1;
            ok = (i_busy_active_low === 1'b1);
        end
        if (ok && b8) begin
            wr(4'h1, {8'h00, w[15:8]});
            wr(4'h0, {8'h00, w[7:0]});
        end else if (ok) begin
            wr(4'h0, w);
        end
    endtask
endmodule

// ==== tb/mhrp_port_bench.sv ====
// self-checking bench for the host register port
`timescale 1ns/100ps
module mhrp_port_bench
    import mhrp_pkg::*;
;
    logic clk = 0, rst = 1, bus8 = 0, load = 0, busy, cv, drst;
    logic [3:0] addr;
    logic cs_n, rd_n, wr_n;
    logic [15:0] wd, rdat, ms, in1, in2, omode;
    logic [63:0] as1, as2, as3, mode1;
    logic [31:0] rv_in, rv, dw, seed = 32'hf3b4_0d4d;
    logic [6:0] code;
    logic [3:0] axes;
    logic [3:0] masks [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6};
    int err_count = 0, n_tests = 0, ax = 0, ncmd = 0, nrst = 0, n0;
    bit ok;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (cv === 1'b1) ncmd++;
        if (drst === 1'b1) nrst++;
    end
    mhrp_host mhrp_host_i (.i_clk(clk), .i_busy_active_low(busy), .i_rdata(rdat), .o_addr(addr),
        .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(wd));
    mhrp_port mhrp_port_i (.i_clk(clk), .i_rst(rst), .i_bus8(bus8), .i_addr(addr), .i_cs_n(cs_n),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(wd), .o_data(rdat), .o_data_oe(),
        .o_busy_active_low(busy), .o_cmd_valid(cv), .o_cmd_code(code), .o_cmd_axes(axes),
        .o_device_reset(drst), .o_main_status_unused(), .i_main_status(ms),
        .i_axis_status_first(as1), .i_axis_error_home_status(as2), .i_axis_interrupt_cause(as3),
        .i_input_pins_first_pair(in1), .i_input_pins_second_pair(in2), .i_read_load(load),
        .i_read_value(rv_in), .o_axis_mode_first(mode1), .o_axis_mode_second(),
        .o_axis_mode_third(), .o_output_mode(omode), .o_interp_mode(), .o_pattern_second_plus(),
        .o_pattern_second_minus(), .o_data_write(dw));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [15:0] exp_word(input logic [2:0] s);
        case (s)
            3'h0: return ms;
            3'h1: return as1[16*ax+:16];
            3'h2: return as2[16*ax+:16];
            3'h3: return as3[16*ax+:16];
            3'h4: return in1;
            3'h5: return in2;
            3'h6: return rv[15:0];
            default: return rv[31:16];
        endcase
    endfunction
    task finish_test();
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task reset_dut(input logic b8);
        rst = 1;
        bus8 = b8;
        repeat (20) @(posedge clk);
        #1 rst = 0;
    endtask
    task new_values();
        @(posedge clk) #1;
        ms = 16'(rnd());
        in1 = 16'(rnd());
        in2 = 16'(rnd());
        as1 = {rnd(), rnd()};
        as2 = {rnd(), rnd()};
        as3 = {rnd(), rnd()};
        rv_in = rnd();
        load = 1;
        @(posedge clk) #1;
        load = 0;
        rv = rv_in;
    endtask
    task sel(input logic [3:0] m);
        mhrp_host_i.cmd(bus8, {4'h0, m, 1'b0, MHRP_CMD_AXIS_SELECT}, ok);
        if (!ok) err_count++;
        if (!ok) finish_test();
        ax = m[0] ? 0 : m[1] ? 1 : m[2] ? 2 : 3;
        chk({9'h0, code}, {9'h0, MHRP_CMD_AXIS_SELECT});
        chk({12'h0, axes}, {12'h0, m});
    endtask
    task rd_all();
        logic [15:0] d, w;
        for (int s = 0; s < 8; s++) begin
            w = exp_word(3'(s));
            if (bus8) begin
                mhrp_host_i.rd({3'(s), 1'b0}, d);
                chk(d, {8'h00, w[7:0]});
                mhrp_host_i.rd({3'(s), 1'b1}, d);
                chk(d, {8'h00, w[15:8]});
            end else begin
                mhrp_host_i.rd({1'b0, 3'(s)}, d);
                chk(d, w);
            end
        end
    endtask
    initial begin
        {ms, in1, in2, rv_in, rv, as1, as2, as3} = '0;
        reset_dut(0);
        for (int k = 0; k < 5; k++) begin
            new_values();
            sel(masks[k]);
            rd_all();
        end
        sel(4'h4);
        mhrp_host_i.wr(4'h1, 16'h5a3c);
        chk(mode1[47:32], 16'h5a3c);
        mhrp_host_i.wr(4'h6, 16'h1234);
        mhrp_host_i.wr(4'h7, 16'hbeef);
        chk(dw[15:0], 16'h1234);
        chk(dw[31:16], 16'hbeef);
        n0 = ncmd;
        sel(4'h1);
        chk({15'h0, busy}, 16'h0000);
        mhrp_host_i.wr(4'h0, {8'h02, 1'b0, MHRP_CMD_AXIS_SELECT});
        repeat (4) @(posedge clk);
        chk(16'(ncmd - n0), 16'h0001);
        chk({12'h0, axes}, 16'h0001);
        mhrp_host_i.cmd(0, MHRP_RESET_WORD, ok);
        sel(4'h1);
        chk(mode1[47:32], 16'h0000);
        chk(16'(nrst), 16'h0001);
        reset_dut(1);
        for (int k = 0; k < 2; k++) begin
            new_values();
            sel(masks[k + 2]);
            rd_all();
        end
        mhrp_host_i.cmd(1, MHRP_RESET_WORD, ok);
        sel(4'h1);
        chk(16'(nrst), 16'h0002);
        finish_test();
    end
endmodule
